// ==== tps_ext_src.sv ====
// External count source model driving both count pins
`timescale 1ns/1ps
module tps_ext_src (
	input wire logic aclk,
	input wire logic go,
	input wire logic [7:0] pulses,
	input wire logic [3:0] half,
	output logic pin_a,
	output logic pin_b,
	output logic busy
);
	// Bursts of pulses; pins stand still between bursts, b is inverse of a
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge aclk);
			if (go === 1'b1) begin
				busy <= 1'b1;
				repeat (pulses) begin
					repeat (half) @(posedge aclk);
					pin_a <= 1'b1;
					pin_b <= 1'b0;
					repeat (half) @(posedge aclk);
					pin_a <= 1'b0;
					pin_b <= 1'b1;
				end
				repeat (4) @(posedge aclk);
				busy <= 1'b0;
			end
		end
	end
endmodule : tps_ext_src

// ==== tps_pin_sync.sv ====
// External count pin synchroniser and edge detector
`timescale 1ns/1ps
module tps_pin_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	input wire logic [2:0] clock_source_select,
	output logic tick
);
	logic lat_q;
	logic sync_ff;
	logic prev_ff;
	logic tick_ff;
	logic nxt_tick;

	// Latch open while clock high
	always_latch begin
		if (aclk) begin
			lat_q = pin; // R07
		end
	end

	// Sampled then previous copy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
			tick_ff <= 1'b0;
		end else begin
			sync_ff <= lat_q; // R06 R07
			prev_ff <= sync_ff;
			tick_ff <= nxt_tick;
		end
	end

	// Edge detect per selected polarity
	always_comb begin
		nxt_tick = 1'b0;
		if (clock_source_select == tps_pkg::CS_EXT_RISE) begin
			nxt_tick = sync_ff & ~prev_ff; // R08 R09 R12 R17
		end else if (clock_source_select == tps_pkg::CS_EXT_FALL) begin
			nxt_tick = ~sync_ff & prev_ff; // R08
		end
	end

	assign tick = tick_ff;
endmodule : tps_pin_sync

// ==== tps_pkg.sv ====
// Package for the shared timer prescaler and tick select block
// Functional notes
// R01: Select value one ticks the timer on every system clock cycle, undivided; code gives no tick while the sync prescaler reset bit is set.
// R02: Prescaler offers taps at clock divided by 8, 64, 256 and 1024.
// R03: Prescaler runs freely, independent of selects, shared by both timers.
// R04: First prescaled tick comes 1 to N+1 cycles after enabling.
// R05: Prescaler reset restarts division phase for both timers at once.
// R06: External pin sampled each cycle; only synchronised sample feeds edge detector.
// R07: Synchroniser is latch transparent on clock high, then rising-edge flops.
// R08: One tick per rising edge at select 7, per falling edge at 6.
// R09: Tick follows pin edge after 2.5 to 3.5 system clock cycles.
// R10: Other party changes external enable only when pin stable one cycle.
// R11: External clock half periods exceed one system clock cycle.
// R12: External pin ticks bypass the prescaler; no division applied.
// R13: While hold mode set, written prescaler reset bits stay set.
// R14: Writing hold mode zero clears both prescaler reset bits together.
// R15: Sync prescaler reset bit resets prescaler, self-clears unless hold mode.
// R16: Select value zero gives no ticks; timer stopped.
// R17: Pin edges tick even when the pin is configured as output.
// R18: Prescaler is 10-bit free counter; taps are single-cycle enable pulses.
package tps_pkg;
	localparam logic [3:0] ADDR_SYNC_CTRL = 4'h0;
	localparam logic [3:0] ADDR_SELECT = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam int SYNC_HOLD_BIT = 7;
	localparam int ASYNC_RST_BIT = 1;
	localparam int SYNC_RST_BIT = 0;
	localparam logic [7:0] SYNC_CTRL_RESET = 8'h00;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIRECT = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESCALE_WIDTH = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Tap enables from the prescaler
	typedef struct packed {
		logic div1024;
		logic div256;
		logic div64;
		logic div8;
	} tps_taps_t;

	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_COLLECT = 3'b010,
		WR_RESP = 3'b100
	} tps_wr_state_t;
endpackage : tps_pkg

// ==== tps_top.sv ====
// Shared prescaler, clock select and sync control with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module tps_top #(
	parameter int PW = tps_pkg::PRESCALE_WIDTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_count_pin_a,
	input wire logic ext_count_pin_b,
	output logic timer_a_tick,
	output logic timer_b_tick,
	output logic async_prescaler_reset
);
	tps_pkg::tps_wr_state_t wst_ff, nxt_wst;
	logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
	logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
	logic [3:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid, arready_ff, nxt_arready;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	logic sync_hold_mode_ff, nxt_sync_hold_mode;
	logic sync_prescaler_reset_ff, nxt_sync_prescaler_reset;
	logic async_rst_ff, nxt_async_rst;
	logic [2:0] sel_a_ff, nxt_sel_a, sel_b_ff, nxt_sel_b;
	logic [PW-1:0] pre_ff, nxt_pre;
	tps_pkg::tps_taps_t taps_ff, nxt_taps;
	logic tick_a_ff, nxt_tick_a, tick_b_ff, nxt_tick_b;
	logic ext_a, ext_b, wr_fire;

	// Write path: collect address and data in either order
	always_comb begin
		nxt_wst = wst_ff;
		nxt_aw_got = aw_got_ff;
		nxt_w_got = w_got_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bresp = bresp_ff;
		wr_fire = 1'b0;
		case (wst_ff)
			tps_pkg::WR_IDLE, tps_pkg::WR_COLLECT: begin
				if (s_axi_awvalid && !aw_got_ff) begin
					nxt_aw_got = 1'b1;
					nxt_awaddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && !w_got_ff) begin
					nxt_w_got = 1'b1;
					nxt_wdata = s_axi_wdata;
					nxt_wstrb = s_axi_wstrb;
				end
				nxt_wst = tps_pkg::WR_COLLECT;
				if (aw_got_ff && w_got_ff) begin
					wr_fire = 1'b1;
					nxt_wst = tps_pkg::WR_RESP;
					nxt_bresp = (awaddr_ff == tps_pkg::ADDR_SYNC_CTRL ||
						awaddr_ff == tps_pkg::ADDR_SELECT ||
						awaddr_ff == tps_pkg::ADDR_STATUS) ?
						tps_pkg::RESP_OKAY : tps_pkg::RESP_SLVERR;
					nxt_aw_got = 1'b0;
					nxt_w_got = 1'b0;
				end
			end
			tps_pkg::WR_RESP: begin
				if (s_axi_bready) begin
					nxt_wst = tps_pkg::WR_IDLE;
				end
			end
			default: nxt_wst = tps_pkg::WR_IDLE;
		endcase
		nxt_awready = (nxt_wst != tps_pkg::WR_RESP) && !nxt_aw_got;
		nxt_wready = (nxt_wst != tps_pkg::WR_RESP) && !nxt_w_got;
		nxt_bvalid = (nxt_wst == tps_pkg::WR_RESP);
	end

	// Write path registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_ff <= tps_pkg::WR_IDLE;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 4'h0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
			bresp_ff <= tps_pkg::RESP_OKAY;
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			bvalid_ff <= 1'b0;
		end else begin
			wst_ff <= nxt_wst;
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bresp_ff <= nxt_bresp;
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bvalid_ff <= nxt_bvalid;
		end
	end

	// Sync control and clock select registers
	always_comb begin
		nxt_sync_hold_mode = sync_hold_mode_ff;
		nxt_async_rst = async_rst_ff;
		nxt_sel_a = sel_a_ff;
		nxt_sel_b = sel_b_ff;
		// Self-clear unless hold mode keeps it
		nxt_sync_prescaler_reset = sync_prescaler_reset_ff & sync_hold_mode_ff; // R15 R13
		if (!sync_hold_mode_ff) begin
			nxt_async_rst = 1'b0; // R14
		end
		if (wr_fire && wstrb_ff[0]) begin
			if (awaddr_ff == tps_pkg::ADDR_SYNC_CTRL) begin
				nxt_sync_hold_mode = wdata_ff[tps_pkg::SYNC_HOLD_BIT];
				if (wdata_ff[tps_pkg::SYNC_HOLD_BIT]) begin
					nxt_sync_prescaler_reset = wdata_ff[tps_pkg::SYNC_RST_BIT]; // R13
					nxt_async_rst = wdata_ff[tps_pkg::ASYNC_RST_BIT]; // R13
				end else begin
					// Pulse once, then hardware clears both
					nxt_sync_prescaler_reset = wdata_ff[tps_pkg::SYNC_RST_BIT]; // R15 R14
					nxt_async_rst = wdata_ff[tps_pkg::ASYNC_RST_BIT]; // R14
				end
			end else if (awaddr_ff == tps_pkg::ADDR_SELECT) begin
				nxt_sel_a = wdata_ff[2:0];
				nxt_sel_b = wdata_ff[6:4];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_hold_mode_ff <= tps_pkg::SYNC_CTRL_RESET[tps_pkg::SYNC_HOLD_BIT];
			sync_prescaler_reset_ff <= tps_pkg::SYNC_CTRL_RESET[tps_pkg::SYNC_RST_BIT];
			async_rst_ff <= tps_pkg::SYNC_CTRL_RESET[tps_pkg::ASYNC_RST_BIT];
			sel_a_ff <= tps_pkg::CS_STOP;
			sel_b_ff <= tps_pkg::CS_STOP;
		end else begin
			sync_hold_mode_ff <= nxt_sync_hold_mode;
			sync_prescaler_reset_ff <= nxt_sync_prescaler_reset;
			async_rst_ff <= nxt_async_rst;
			sel_a_ff <= nxt_sel_a;
			sel_b_ff <= nxt_sel_b;
		end
	end

	// Read path, one read outstanding
	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end else if (!rvalid_ff && s_axi_arvalid) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = tps_pkg::RESP_OKAY;
			case (s_axi_araddr)
				tps_pkg::ADDR_SYNC_CTRL: nxt_rdata = {24'h0, sync_hold_mode_ff, 5'h0,
					async_rst_ff, sync_prescaler_reset_ff};
				tps_pkg::ADDR_SELECT: nxt_rdata = {25'h0, sel_b_ff, 1'b0, sel_a_ff};
				tps_pkg::ADDR_STATUS: nxt_rdata = {{(32-PW){1'b0}}, pre_ff};
				default: begin
					nxt_rdata = 32'h0;
					nxt_rresp = tps_pkg::RESP_SLVERR;
				end
			endcase
		end
		nxt_arready = !nxt_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
			rdata_ff <= 32'h0;
			rresp_ff <= tps_pkg::RESP_OKAY;
		end else begin
			rvalid_ff <= nxt_rvalid;
			arready_ff <= nxt_arready;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	// Free-running prescaler and tap pulses
	always_comb begin
		nxt_pre = pre_ff + {{(PW-1){1'b0}}, 1'b1}; // R03 R18
		nxt_taps.div8 = (nxt_pre[2:0] == 3'h0); // R02 R04
		nxt_taps.div64 = (nxt_pre[5:0] == 6'h00); // R02
		nxt_taps.div256 = (nxt_pre[7:0] == 8'h00); // R02
		nxt_taps.div1024 = (nxt_pre[9:0] == 10'h000); // R02
		if (sync_prescaler_reset_ff) begin
			nxt_pre = '0; // R05
			nxt_taps = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_ff <= '0;
			taps_ff <= '0;
		end else begin
			pre_ff <= nxt_pre;
			taps_ff <= nxt_taps;
		end
	end

	// Per-timer source selection
	function automatic logic pick(input logic [2:0] sel, input tps_pkg::tps_taps_t t,
		input logic ext);
		logic r;
		r = 1'b0;
		case (sel)
			tps_pkg::CS_STOP: r = 1'b0; // R16
			tps_pkg::CS_DIRECT: r = 1'b1; // R01
			tps_pkg::CS_DIV8: r = t.div8;
			tps_pkg::CS_DIV64: r = t.div64;
			tps_pkg::CS_DIV256: r = t.div256;
			tps_pkg::CS_DIV1024: r = t.div1024;
			default: r = ext; // R12
		endcase
		return r;
	endfunction : pick

	always_comb begin
		nxt_tick_a = pick(sel_a_ff, taps_ff, ext_a) & ~sync_prescaler_reset_ff;
		nxt_tick_b = pick(sel_b_ff, taps_ff, ext_b) & ~sync_prescaler_reset_ff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_a_ff <= 1'b0;
			tick_b_ff <= 1'b0;
		end else begin
			tick_a_ff <= nxt_tick_a;
			tick_b_ff <= nxt_tick_b;
		end
	end

	tps_pin_sync u_sync_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(ext_count_pin_a),
		.clock_source_select(sel_a_ff),
		.tick(ext_a)
	);

	tps_pin_sync u_sync_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(ext_count_pin_b),
		.clock_source_select(sel_b_ff),
		.tick(ext_b)
	);

	// Output drive
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign timer_a_tick = tick_a_ff;
	assign timer_b_tick = tick_b_ff;
	assign async_prescaler_reset = async_rst_ff;

	// Checks
	property p_direct;
		@(posedge aclk) disable iff (!aresetn)
		(sel_a_ff == tps_pkg::CS_DIRECT && !sync_prescaler_reset_ff) |=> timer_a_tick;
	endproperty
	a_direct: assert property (p_direct) else $error("direct tick missing"); // R01
	property p_stop;
		@(posedge aclk) disable iff (!aresetn)
		(sel_a_ff == tps_pkg::CS_STOP) |=> !timer_a_tick;
	endproperty
	a_stop: assert property (p_stop) else $error("tick while stopped"); // R16
	property p_div8;
		@(posedge aclk) disable iff (!aresetn)
		taps_ff.div8 && !sync_prescaler_reset_ff |=> !taps_ff.div8 [*7];
	endproperty
	a_div8: assert property (p_div8) else $error("div8 spacing wrong"); // R02
	// A restart in any of the next seven cycles moves the next pulse, so the next eight cycles are excluded
	property p_div8_next;
		@(posedge aclk) disable iff (!aresetn)
		(taps_ff.div8 && !sync_prescaler_reset_ff) ##1 (!sync_prescaler_reset_ff [*8])
			|-> taps_ff.div8;
	endproperty
	a_div8_next: assert property (p_div8_next) else $error("div8 late"); // R04 R18
	property p_rst_phase;
		@(posedge aclk) disable iff (!aresetn)
		sync_prescaler_reset_ff |=> (pre_ff == '0);
	endproperty
	a_rst_phase: assert property (p_rst_phase) else $error("prescaler not restarted"); // R05
	property p_self_clear;
		@(posedge aclk) disable iff (!aresetn)
		(sync_prescaler_reset_ff && !sync_hold_mode_ff && !wr_fire) |=> !sync_prescaler_reset_ff;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("reset bit stuck"); // R15
	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
		(sync_prescaler_reset_ff && sync_hold_mode_ff && !wr_fire) |=> sync_prescaler_reset_ff;
	endproperty
	a_hold: assert property (p_hold) else $error("held reset lost"); // R13
	property p_release;
		@(posedge aclk) disable iff (!aresetn)
		$fell(sync_hold_mode_ff) |=> (!sync_prescaler_reset_ff && !async_rst_ff);
	endproperty
	a_release: assert property (p_release) else $error("release failed"); // R14
	property p_no_tick_in_reset;
		@(posedge aclk) disable iff (!aresetn)
		sync_prescaler_reset_ff && sel_b_ff inside {[3'h2:3'h5]} |=> !timer_b_tick;
	endproperty
	a_no_tick_in_reset: assert property (p_no_tick_in_reset) else $error("tick in reset"); // R05
	c_div1024: cover property (@(posedge aclk) taps_ff.div1024);
	c_ext_a: cover property (@(posedge aclk) ext_a ##1 timer_a_tick);
	c_hold: cover property (@(posedge aclk) $fell(sync_hold_mode_ff));
	c_both: cover property (@(posedge aclk) timer_a_tick && timer_b_tick);
endmodule : tps_top

// ==== tps_top_tb_top.sv ====
// Self-checking testbench for the shared prescaler and tick select block
`timescale 1ns/1ps
module tps_top_tb_top;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, pin_a, pin_b, tick_a, tick_b, apr, go, busy;
	logic [3:0] awaddr, araddr, wstrb, half;
	logic [31:0] wdata, rdata, seed, rd;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] pulses;
	logic [2:0] csa, csb;
	int fail_count = 0;
	int num_checks = 0;
	int ca, cb, na, nb, fa;

	// Design and far-side model
	tps_top #(.PW(10)) tps_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_count_pin_a(pin_a),
		.ext_count_pin_b(pin_b), .timer_a_tick(tick_a), .timer_b_tick(tick_b),
		.async_prescaler_reset(apr));
	tps_ext_src tps_ext_src_inst (.aclk(aclk), .go(go), .pulses(pulses), .half(half),
		.pin_a(pin_a), .pin_b(pin_b), .busy(busy));

	// Clock of 100 ns period
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Watchdog
	initial begin
		#(60000 * 100);
		fail_count++;
		end_sim();
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic int exp_ticks(input logic [2:0] cs, input int n);
		case (cs)
			tps_pkg::CS_DIRECT: return n;
			tps_pkg::CS_DIV8: return n / 8;
			tps_pkg::CS_DIV64: return n / 64;
			tps_pkg::CS_DIV256: return n / 256;
			tps_pkg::CS_DIV1024: return n / 1024;
			default: return 0;
		endcase
	endfunction : exp_ticks

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("Checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	// Ready sampled at the falling edge, released by the next rising edge
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
		end while (tb !== 1'b1 && n < 200);
		if (tb !== 1'b1) fail_count++;
		bready <= 1'b0;
	endtask : wr

	task automatic rd_reg(input logic [3:0] a);
		logic ta, tr;
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rvalid;
			rd = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			n++;
		end while (tr !== 1'b1 && n < 200);
		if (tr !== 1'b1) fail_count++;
		rready <= 1'b0;
	endtask : rd_reg

	task automatic count(input int n);
		ca = 0;
		cb = 0;
		repeat (4) @(posedge aclk);
		repeat (n) begin
			@(negedge aclk);
			ca += (tick_a === 1'b1);
			cb += (tick_b === 1'b1);
		end
	endtask : count

	task automatic run_ext(input logic [7:0] p, input logic [3:0] h);
		int n;
		pulses <= p;
		half <= h;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		ca = 0;
		cb = 0;
		n = 0;
		fa = 0;
		do begin
			@(negedge aclk);
			ca += (tick_a === 1'b1);
			cb += (tick_b === 1'b1);
			n++;
			if (fa == 0 && tick_a === 1'b1) fa = n;
		end while (busy === 1'b1 && n < 3000);
		if (busy === 1'b1) fail_count++;
	endtask : run_ext

	// Main sequence
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, go} = 6'h00;
		{awaddr, araddr, wstrb, wdata} = 44'h0;
		pulses = 8'h00;
		half = 4'h2;
		seed = 32'h47C1;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(tps_pkg::ADDR_SYNC_CTRL);
		check("sync_ctrl_reset", rd, {24'h0, tps_pkg::SYNC_CTRL_RESET});
		rd_reg(tps_pkg::ADDR_SELECT);
		check("select_reset", rd, 32'h0);
		rd_reg(4'hC);
		check("unmapped_rresp", {30'h0, resp}, {30'h0, tps_pkg::RESP_SLVERR});
		wr(4'hC, 32'hFF);
		check("unmapped_bresp", {30'h0, resp}, {30'h0, tps_pkg::RESP_SLVERR});
		$display("Test registers done");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			csa = 3'(i);
			csb = 3'(seed % 6);
			wr(tps_pkg::ADDR_SELECT, {25'h0, csb, 1'b0, csa});
			count(2048);
			check("ticks_a", ca, exp_ticks(csa, 2048));
			check("ticks_b", cb, exp_ticks(csb, 2048));
		end
		$display("Test internal taps done");
		wr(tps_pkg::ADDR_SELECT, {25'h0, tps_pkg::CS_EXT_FALL, 1'b0, tps_pkg::CS_EXT_RISE});
		repeat (3) begin
			seed = lfsr(seed);
			run_ext(8'(seed[4:0] + 1), 4'(seed[9:8] + 2));
			check("ext_rise_a", ca, 32'(pulses));
			check("ext_fall_b", cb, 32'(pulses));
			// First rise half cycles after go is seen one cycle in, then three cycles of pin latency
			check("ext_latency_a", fa, 32'(half) + 32'h4);
		end
		$display("Test external edges done");
		wr(tps_pkg::ADDR_SELECT, {25'h0, tps_pkg::CS_DIRECT, 1'b0, tps_pkg::CS_DIRECT});
		wr(tps_pkg::ADDR_SYNC_CTRL, 32'h83);
		check("mapped_bresp", {30'h0, resp}, {30'h0, tps_pkg::RESP_OKAY});
		rd_reg(tps_pkg::ADDR_SYNC_CTRL);
		check("hold_kept", rd, 32'h83);
		check("async_rst", {31'h0, apr}, 32'h1);
		rd_reg(tps_pkg::ADDR_STATUS);
		check("pre_held", rd, 32'h0);
		count(50);
		check("held_a", ca + cb, 32'h0);
		wr(tps_pkg::ADDR_SYNC_CTRL, 32'h0);
		rd_reg(tps_pkg::ADDR_SYNC_CTRL);
		check("hold_clear", rd, 32'h0);
		count(50);
		check("run_a", ca, 32'd50);
		check("run_b", cb, 32'd50);
		wr(tps_pkg::ADDR_SYNC_CTRL, 32'h01);
		rd_reg(tps_pkg::ADDR_SYNC_CTRL);
		check("self_clear", rd, 32'h0);
		$display("Test sync mode done");
		wr(tps_pkg::ADDR_SELECT, {25'h0, tps_pkg::CS_DIV64, 1'b0, tps_pkg::CS_DIV8});
		wr(tps_pkg::ADDR_SYNC_CTRL, 32'h01);
		na = 0;
		nb = 0;
		for (int i = 1; i < 80; i++) begin
			@(negedge aclk);
			if (na == 0 && tick_a === 1'b1) na = i;
			if (nb == 0 && tick_b === 1'b1) nb = i;
		end
		check("first_a", {31'h0, na > 0 && na <= 10}, 32'h1);
		check("first_b", {31'h0, nb > 0 && nb <= 66}, 32'h1);
		$display("Test prescaler restart done");
		end_sim();
	end
endmodule : tps_top_tb_top
